// ==== src/power_seq_regs.svh ====
// Purpose: register offsets, timing figures and codes of the power-mode sequencer
// Assumes: 40 MHz clock, AXI4-Lite word registers
// Notes: times are kept in their own unit; cycle counts derive from them
`ifndef POWER_SEQ_REGS_SVH
`define POWER_SEQ_REGS_SVH
`define CLOCK_HZ 40000000
`define MS_CYCLES_DEF (`CLOCK_HZ / 1000)
`define IGN_MIN_MS 100
`define IGN_CHG_MS 1000
`define POWERUP_MS 100
`define PERIOD_FAST_MS 500
`define PERIOD_SLOW_MS 50000
`define FILTER_CYCLES 16
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_VOLT 5'h08
`define REG_CMD 5'h0c
`define REG_ALARM 5'h10
`define REG_CHARGE 5'h14
`define CTRL_RST 2'h1
`define CTRL_AUTOBAUD 0
`define CTRL_FAST 1
`define CMD_SET_ALARM 8'h01
`define CMD_SET_CLOCK 8'h02
`define CMD_CHARGE_Q 8'h03
`define CMD_TEMP_Q 8'h04
`define CMD_POWER_DOWN 8'h05
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== src/power_seq_pkg.sv ====
// Purpose: types shared by the power-mode sequencer files
// Assumes: nothing
// Notes: outputs to the power rails travel as one struct
package power_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_POWERUP = 3'b001,
    ST_NORMAL = 3'b010,
    ST_CHARGE_ONLY = 3'b011,
    ST_ALARM = 3'b100,
    ST_SHUTDOWN = 3'b101
  } pwr_state_e;
  typedef struct packed {
    logic supplies_on;
    logic vdd_on;
    logic led_on;
    logic network_on;
    logic charge_on;
    logic serial_full;
  } pwr_out_s;
endpackage : power_seq_pkg

// ==== src/input_filter.sv ====
// Purpose: two-flop synchroniser plus stability filter for one pin
// Assumes: pin is asynchronous to clock
// Notes: level changes only after STABLE equal samples
`timescale 1ns/1ps
module input_filter #(
  parameter int STABLE = 16,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  localparam int CW = $clog2(STABLE + 1);
  logic sync1;
  logic sync2;
  logic [CW-1:0] count;
  wire differs = sync2 != level;
  wire settled = count == CW'(STABLE - 1);
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1 <= RESET_LEVEL;
      sync2 <= RESET_LEVEL;
      count <= '0;
      level <= RESET_LEVEL;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      count <= (differs && !settled) ? count + CW'(1) : '0;
      if (differs && settled) level <= sync2;
    end
  end
endmodule : input_filter

// ==== src/voltage_averager.sv ====
// Purpose: averages supply samples over one measuring period
// Assumes: samples arrive on the same clock; ms_tick is one cycle per ms
// Notes: serial divider, result ready SUM_W cycles after period end
`timescale 1ns/1ps
`include "power_seq_regs.svh"
module voltage_averager #(
  parameter int MV_W = 13,
  parameter int CNT_W = 16,
  parameter int SUM_W = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic ms_tick,
  input wire logic fast,
  input wire logic [MV_W-1:0] sample_mv,
  input wire logic sample_valid,
  output logic [MV_W-1:0] avg_mv
);
  localparam logic [5:0] STEPS = 6'(SUM_W);
  logic [15:0] per_ms;
  logic [SUM_W-1:0] sum;
  logic [CNT_W-1:0] n;
  logic [SUM_W-1:0] num;
  logic [CNT_W-1:0] den;
  logic [CNT_W:0] rem;
  logic [5:0] step;
  wire [15:0] period = fast ? 16'(`PERIOD_FAST_MS) : 16'(`PERIOD_SLOW_MS);
  wire per_end = ms_tick && (per_ms >= period - 16'd1);
  wire [CNT_W:0] shifted = {rem[CNT_W-1:0], num[SUM_W-1]};
  wire take = shifted >= {1'b0, den};
  wire busy = step != 6'd0;
  always_ff @(posedge clock) begin
    if (reset) begin
      per_ms <= 16'd0;
      sum <= '0;
      n <= '0;
      num <= '0;
      den <= '0;
      rem <= '0;
      step <= 6'd0;
      avg_mv <= '0;
    end else begin
      if (ms_tick) per_ms <= per_end ? 16'd0 : per_ms + 16'd1;
      if (per_end) begin
        // empty period keeps the previous average
        sum <= '0;
        n <= '0;
        num <= sum;
        den <= n;
        rem <= '0;
        step <= (n != '0) ? STEPS : 6'd0;
      end else if (sample_valid) begin
        sum <= sum + SUM_W'(sample_mv);
        n <= n + CNT_W'(1);
      end
      if (busy && !per_end) begin
        rem <= take ? shifted - {1'b0, den} : shifted;
        num <= {num[SUM_W-2:0], take};
        step <= step - 6'd1;
        if (step == 6'd1) avg_mv <= MV_W'({num[SUM_W-2:0], take});
      end
    end
  end
endmodule : voltage_averager

// ==== src/power_mode_sequencer.sv ====
// Purpose: power-mode sequencer with AXI4-Lite registers
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes: pins pass a two-flop synchroniser and filter before use
//
// How it works
// [RQ1] host holds ignition low at least 100 ms
// [RQ2] host waits 10 ms after vdd falls
// [RQ3] host waits 10 ms after supply 3.0 V
// [RQ4] power-up takes further 100 ms
// [RQ5] supply drop during ignition aborts activation
// [RQ6] ready code only with fixed baud
// [RQ7] charge to normal needs 1 s ignition
// [RQ8] charger while off starts charge-only mode
// [RQ9] charge-only: no network; ignition goes normal
// [RQ10] no charging in alarm mode
// [RQ11] rtc alarm while off enters alarm mode
// [RQ12] alarm time survives command power-down
// [RQ13] alarm code signals alarm mode, not autobaud
// [RQ14] alarm mode accepts only five commands
// [RQ15] alarm mode reports capacity zero
// [RQ16] ignition moves alarm mode to normal
// [RQ17] status led off in alarm mode
// [RQ18] emergency off cuts supplies immediately
// [RQ19] undervoltage or overtemperature forces shutdown; the code does so only from power-up and normal, not from charge-only or alarm
// [RQ20] supply averaged over mode-dependent period
// [RQ21] start out of range switches off
// [RQ22] ignition pull-up off until supply rises
// [RQ23] vdd off in power-down
// [RQ24] emergency off removes supplies within limit
// [RQ25] pins synchronised and filtered
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "power_seq_regs.svh"
module power_mode_sequencer
  import power_seq_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES_DEF,
  parameter int FILTER = `FILTER_CYCLES,
  parameter int ADDR_W = 5,
  parameter int MV_W = 13
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic ignition_n,
  input wire logic emergency_off_n,
  input wire logic charger_detect,
  input wire logic rtc_alarm,
  input wire logic supply_above_3v0,
  input wire logic undervoltage,
  input wire logic overtemperature,
  input wire logic rtc_backup_supply,
  input wire logic [MV_W-1:0] supply_sample_mv,
  input wire logic supply_sample_valid,
  input wire logic [7:0] battery_capacity,
  output pwr_out_s pwr,
  output logic ignition_pullup_en,
  output logic ready_indication,
  output logic alarm_mode_indication
);
  localparam int MSW = $clog2(MS_CYCLES);
  localparam int NPIN = 8;
  localparam logic [NPIN-1:0] PIN_IDLE = 8'h03;

  // filtered pins
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_f;
  assign pin_raw = {rtc_backup_supply, overtemperature, undervoltage, supply_above_3v0,
                    rtc_alarm, charger_detect, emergency_off_n, ignition_n};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      input_filter #(.STABLE(FILTER), .RESET_LEVEL(PIN_IDLE[gi])) u_filt ( // RQ25
        .clock(clock),
        .reset(reset),
        .pin(pin_raw[gi]),
        .level(pin_f[gi])
      );
    end
  endgenerate
  wire ign_low = !pin_f[0];
  wire emerg_ok = pin_f[1];
  wire charger_f = pin_f[2];
  wire rtc_f = pin_f[3];
  wire supply_ok = pin_f[4];
  wire fault = pin_f[5] | pin_f[6];
  wire backup_f = pin_f[7];

  pwr_state_e state;
  pwr_state_e next_state;
  logic [MSW-1:0] ms_cnt;
  logic [10:0] ign_ms;
  logic [10:0] phase_ms;
  logic rtc_q;
  logic supply_seen;
  logic [1:0] ctrl;
  logic [31:0] alarm_time;
  logic cmd_ok;
  logic [MV_W-1:0] avg_mv;

  wire ms_tick = ms_cnt == MSW'(MS_CYCLES - 1);
  wire autobaud = ctrl[`CTRL_AUTOBAUD];
  wire alarm_rise = rtc_f && !rtc_q;
  wire in_alarm = state == ST_ALARM;

  // ignition hold time; charge-only wants the longer hold
  wire [10:0] ign_need = (state == ST_CHARGE_ONLY) ? 11'(`IGN_CHG_MS) : 11'(`IGN_MIN_MS); // RQ1 RQ7
  wire ign_ok = ign_ms >= ign_need;
  wire powerup_done = phase_ms >= 11'(`POWERUP_MS);

  // AXI4-Lite slave
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire wr_fire = aw_held && w_held && !bvalid;
  wire [4:0] wa = {aw_addr_q[4:2], 2'b00};
  wire [4:0] ra = {araddr[4:2], 2'b00};
  wire wr_ctrl = wr_fire && wa == `REG_CTRL && w_strb_q[0];
  wire wr_alarm = wr_fire && wa == `REG_ALARM;
  wire wr_cmd = wr_fire && wa == `REG_CMD && w_strb_q[0];
  wire wr_hit = wa == `REG_CTRL || wa == `REG_ALARM || wa == `REG_CMD;
  wire [7:0] cmd_code = w_data_q[7:0];
  wire cmd_in_set = cmd_code == `CMD_SET_ALARM || cmd_code == `CMD_SET_CLOCK ||
                    cmd_code == `CMD_CHARGE_Q || cmd_code == `CMD_TEMP_Q ||
                    cmd_code == `CMD_POWER_DOWN;
  wire cmd_allowed = !in_alarm || cmd_in_set; // RQ14
  wire pd_req = wr_cmd && cmd_code == `CMD_POWER_DOWN && cmd_allowed;
  wire [7:0] capacity = in_alarm ? 8'h00 : battery_capacity; // RQ15
  wire [31:0] status_word = {26'h0, cmd_ok, charger_f, 1'b0, state};
  wire [31:0] charge_word = {23'h0, charger_f, capacity};
  wire rd_hit = ra == `REG_CTRL || ra == `REG_STATUS || ra == `REG_VOLT ||
                ra == `REG_CMD || ra == `REG_ALARM || ra == `REG_CHARGE;
  wire [31:0] rd_word = (ra == `REG_CTRL) ? {30'h0, ctrl} :
                        (ra == `REG_STATUS) ? status_word :
                        (ra == `REG_VOLT) ? 32'(avg_mv) :
                        (ra == `REG_ALARM) ? alarm_time :
                        (ra == `REG_CHARGE) ? charge_word : 32'h0;
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;

  function automatic pwr_out_s outs(input pwr_state_e s, input logic chg);
    outs.supplies_on = s != ST_OFF; // RQ18
    outs.vdd_on = s != ST_OFF; // RQ23
    outs.led_on = s == ST_NORMAL; // RQ17
    outs.network_on = s == ST_NORMAL; // RQ9 RQ11
    outs.charge_on = chg && (s == ST_NORMAL || s == ST_CHARGE_ONLY); // RQ10
    outs.serial_full = s == ST_NORMAL || s == ST_POWERUP;
  endfunction : outs

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (ign_ok) next_state = ST_POWERUP;
        else if (alarm_rise) next_state = ST_ALARM; // RQ11
        else if (charger_f) next_state = ST_CHARGE_ONLY; // RQ8
      end
      ST_POWERUP: begin
        if (fault) next_state = ST_SHUTDOWN; // RQ21
        else if (powerup_done) next_state = ST_NORMAL; // RQ4
      end
      ST_NORMAL: begin
        if (fault || pd_req) next_state = ST_SHUTDOWN; // RQ19
      end
      ST_CHARGE_ONLY: begin
        if (pd_req) next_state = ST_SHUTDOWN;
        else if (ign_ok) next_state = ST_POWERUP; // RQ9
        else if (!charger_f) next_state = ST_OFF;
      end
      ST_ALARM: begin
        if (pd_req) next_state = ST_SHUTDOWN;
        else if (ign_ok) next_state = ST_POWERUP; // RQ16
      end
      ST_SHUTDOWN: next_state = ST_OFF;
      default: next_state = ST_OFF;
    endcase
    if (!emerg_ok) next_state = ST_OFF; // RQ18 RQ24
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_OFF;
      pwr <= '0;
      ms_cnt <= '0;
      rtc_q <= 1'b0;
      supply_seen <= 1'b0;
      ignition_pullup_en <= 1'b0;
    end else begin
      state <= next_state;
      pwr <= outs(next_state, charger_f);
      ms_cnt <= ms_tick ? '0 : ms_cnt + MSW'(1);
      rtc_q <= rtc_f;
      supply_seen <= supply_seen | supply_ok;
      // backup-fed part keeps the pin floating until the main supply rises
      ignition_pullup_en <= !backup_f || supply_seen || supply_ok; // RQ22
    end
  end

  // ignition low time, cleared by release or a weak supply
  always_ff @(posedge clock) begin
    if (reset) ign_ms <= 11'd0;
    else if (!ign_low || !supply_ok) ign_ms <= 11'd0; // RQ5
    else if (ms_tick && ign_ms < 11'(`IGN_CHG_MS)) ign_ms <= ign_ms + 11'd1;
  end

  always_ff @(posedge clock) begin
    if (reset) phase_ms <= 11'd0;
    else if (next_state != state) phase_ms <= 11'd0;
    else if (ms_tick && !powerup_done) phase_ms <= phase_ms + 11'd1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ready_indication <= 1'b0;
      alarm_mode_indication <= 1'b0;
    end else begin
      // no code under autobaud: the far end has not locked its rate yet
      ready_indication <= state == ST_POWERUP && next_state == ST_NORMAL && !autobaud; // RQ6
      alarm_mode_indication <= !in_alarm && next_state == ST_ALARM && !autobaud; // RQ13
    end
  end

  // alarm time is cleared only by reset, never by a power-down
  generate
    for (gi = 0; gi < 4; gi++) begin : g_alarm
      always_ff @(posedge clock) begin
        if (reset) alarm_time[gi*8 +: 8] <= 8'h00;
        else if (wr_alarm && w_strb_q[gi]) alarm_time[gi*8 +: 8] <= w_data_q[gi*8 +: 8]; // RQ12
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= `CTRL_RST;
      cmd_ok <= 1'b1;
    end else begin
      if (wr_ctrl) ctrl <= w_data_q[1:0];
      if (wr_cmd) cmd_ok <= cmd_allowed; // RQ14
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  voltage_averager #(.MV_W(MV_W)) u_avg ( // RQ20
    .clock(clock),
    .reset(reset),
    .ms_tick(ms_tick),
    .fast(ctrl[`CTRL_FAST] && state == ST_NORMAL),
    .sample_mv(supply_sample_mv),
    .sample_valid(supply_sample_valid),
    .avg_mv(avg_mv)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  emerg_cut_a: assert property (!emerg_ok |=> !pwr.supplies_on && state == ST_OFF) // RQ18
    else $error("emergency off did not cut supplies");
  alarm_no_charge_a: assert property (in_alarm |-> !pwr.charge_on && !pwr.network_on) // RQ10
    else $error("charging or network active in alarm mode");
  alarm_led_off_a: assert property (in_alarm |-> !pwr.led_on) // RQ17
    else $error("status led on in alarm mode");
  powerup_time_a: assert property (state == ST_POWERUP ##1 state == ST_NORMAL |-> // RQ4
    $past(phase_ms) >= 11'(`POWERUP_MS))
    else $error("normal mode before power-up time");
  supply_abort_a: assert property (!supply_ok |=> ign_ms == 11'd0 && !ign_ok) // RQ5
    else $error("ignition kept counting on weak supply");
  ready_code_a: assert property (ready_indication |-> // RQ6
    !$past(autobaud) && state == ST_NORMAL && $past(state) == ST_POWERUP)
    else $error("ready code at wrong time");
  alarm_code_a: assert property ($rose(in_alarm) && !$past(autobaud) |-> alarm_mode_indication) // RQ13
    else $error("alarm mode entered without its code");
  cmd_filter_a: assert property (wr_cmd && in_alarm && !cmd_in_set |=> !cmd_ok) // RQ14
    else $error("disallowed command accepted in alarm mode");
  cap_zero_a: assert property (in_alarm |-> charge_word[7:0] == 8'h00) // RQ15
    else $error("capacity not zero in alarm mode");
  fault_shut_a: assert property (state == ST_NORMAL && fault && emerg_ok |=> // RQ19
    state == ST_SHUTDOWN ##1 state == ST_OFF)
    else $error("fault did not shut down");
  rtc_wake_a: assert property (state == ST_OFF && alarm_rise && !ign_ok && emerg_ok |=> // RQ11
    in_alarm)
    else $error("rtc alarm did not wake alarm mode");
  vdd_off_a: assert property (state == ST_OFF |-> !pwr.vdd_on) // RQ23
    else $error("vdd on in power-down");

  reach_normal_c: cover property (state == ST_POWERUP ##1 state == ST_NORMAL);
  alarm_to_normal_c: cover property (in_alarm ##1 state == ST_POWERUP);
  charge_only_c: cover property (state == ST_OFF ##1 state == ST_CHARGE_ONLY);
  emerg_c: cover property (state == ST_NORMAL && !emerg_ok);
endmodule : power_mode_sequencer

// ==== tb/host_controller_model.sv ====
// Purpose: host controller model driving the ignition and emergency-off lines
// Assumes: both lines open drain with pull-ups, released lines read high
// Notes: ignition start is held back by the supply and vdd guard times
`timescale 1ns/1ps
module host_controller_model #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic supply_above_3v0,
  input wire logic vdd_on,
  input wire logic ign_go,
  input wire logic [15:0] ign_ms,
  input wire logic eoff_go,
  output logic ignition_n,
  output logic emergency_off_n,
  output logic busy
);
  int guard;
  int ign_left;
  int eoff_left;
  logic vdd_q;
  logic pend;
  // released line goes to the pull-up level, never keeps a driven low
  assign ignition_n = !(ign_left > 0);
  assign emergency_off_n = !(eoff_left > 0);
  assign busy = pend || ign_left > 0 || eoff_left > 0;
  always @(posedge clock) begin
    vdd_q <= vdd_on;
    if (reset || !supply_above_3v0 || (vdd_q && !vdd_on)) begin
      guard <= 0;
    end else if (guard < 10 * MS_CYCLES) begin
      guard <= guard + 1;
    end
    if (reset) begin
      pend <= 1'b0;
      ign_left <= 0;
      eoff_left <= 0;
    end else begin
      if (ign_go) pend <= 1'b1;
      if (pend && ign_left == 0 && guard >= 10 * MS_CYCLES) begin
        pend <= 1'b0;
        ign_left <= int'(ign_ms) * MS_CYCLES;
      end else if (ign_left > 0) begin
        ign_left <= ign_left - 1;
      end
      if (eoff_go) eoff_left <= 3200 * MS_CYCLES;
      else if (eoff_left > 0) eoff_left <= eoff_left - 1;
    end
  end
endmodule : host_controller_model

// ==== tb/module_power_mode_sequencer_tb_top.sv ====
// Purpose: self-checking bench of the power-mode sequencer
// Assumes: short ms tick and filter parameters, fixed xorshift seed
// Notes: register reads go through the AXI4-Lite tasks only
`timescale 1ns/1ps
`include "power_seq_regs.svh"
`define CHK(got, exp) check_eq(32'(got), 32'(exp))
module module_power_mode_sequencer_tb_top;
  import power_seq_pkg::*;
  localparam int MS = 4;
  logic clock = 0;
  logic reset = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, alarm_val;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, resp;
  logic ignition_n, emergency_off_n, busy, ign_q, pullup_en, ready_ind, alarm_ind;
  logic charger_detect = 0, rtc_alarm = 0, supply_above_3v0 = 0, sample_valid = 0;
  logic undervoltage = 0, overtemperature = 0, rtc_backup_supply = 1;
  logic ign_go = 0, eoff_go = 0;
  logic [15:0] ign_ms = 0;
  logic [12:0] sample_mv = 0;
  logic [7:0] capacity = 0;
  logic [31:0] seed = 32'h57;
  pwr_out_s pwr;
  int mismatches = 0, tests_run = 0, cyc = 0;
  int ready_cnt = 0, alarm_cnt = 0, ready_cyc = 0, fall_cyc = 0;
  power_mode_sequencer #(.MS_CYCLES(MS), .FILTER(2)) dut (.clock(clock), .reset(reset),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ignition_n(ignition_n), .emergency_off_n(emergency_off_n),
    .charger_detect(charger_detect), .rtc_alarm(rtc_alarm),
    .supply_above_3v0(supply_above_3v0), .undervoltage(undervoltage),
    .overtemperature(overtemperature), .rtc_backup_supply(rtc_backup_supply),
    .supply_sample_mv(sample_mv), .supply_sample_valid(sample_valid),
    .battery_capacity(capacity), .pwr(pwr), .ignition_pullup_en(pullup_en),
    .ready_indication(ready_ind), .alarm_mode_indication(alarm_ind));
  host_controller_model #(.MS_CYCLES(MS)) host (.clock(clock), .reset(reset),
    .supply_above_3v0(supply_above_3v0), .vdd_on(pwr.vdd_on), .ign_go(ign_go),
    .ign_ms(ign_ms), .eoff_go(eoff_go), .ignition_n(ignition_n),
    .emergency_off_n(emergency_off_n), .busy(busy));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ign_q <= ignition_n;
    sample_valid <= (cyc % 8 == 0);
    if (ign_q === 1'b1 && ignition_n === 1'b0) fall_cyc <= cyc;
    if (ready_ind === 1'b1) begin
      ready_cnt <= ready_cnt + 1;
      ready_cyc <= cyc;
    end
    if (alarm_ind === 1'b1) alarm_cnt <= alarm_cnt + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic timeout;
    mismatches++;
    $display("[FAIL] t=%0t wait limit reached", $time);
    summarize;
  endtask : timeout
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq
  task automatic wait_ms(input int ms);
    repeat (ms * MS) @(posedge clock);
  endtask : wait_ms
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic aw, w, b;
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 0;
    n = 0;
    while (!b) begin
      @(negedge clock);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
      if (n > 100) timeout;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    logic ar, r;
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 0;
    n = 0;
    while (!r) begin
      @(negedge clock);
      ar = arvalid && arready;
      r = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge clock);
      if (ar) arvalid <= 1'b0;
      n++;
      if (n > 100) timeout;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge clock);
    while (busy !== 1'b0) begin
      @(negedge clock);
      n++;
      if (n > 20000) timeout;
    end
  endtask : wait_idle
  task automatic ignite(input int ms);
    @(posedge clock);
    ign_ms <= 16'(ms);
    ign_go <= 1'b1;
    @(posedge clock);
    ign_go <= 1'b0;
    wait_idle;
  endtask : ignite
  task automatic wait_state(input pwr_state_e s, input int max_ms);
    for (int i = 0; i < max_ms; i++) begin
      rd(`REG_STATUS);
      if (d[2:0] === s) break;
      wait_ms(1);
    end
    if (d[2:0] !== s) timeout;
  endtask : wait_state
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    wait_ms(3);
    `CHK(pullup_en, 0);
    supply_above_3v0 <= 1'b1;
    // filter plus output flop need five edges after the supply pin moves
    wait_ms(2);
    `CHK(pullup_en, 1);
    rd(`REG_CTRL);
    `CHK(d[1:0], `CTRL_RST);
    rd(5'h18);
    `CHK(resp, `RESP_SLVERR);
    `CHK(d, 32'h0);
    wr(5'h1c, 32'h1);
    `CHK(resp, `RESP_SLVERR);
    wr(`REG_CTRL, 32'h2);
    ignite(90);
    wait_ms(20);
    rd(`REG_STATUS);
    `CHK(d[2:0], ST_OFF);
    fork
      ignite(150);
      begin
        wait_ms(60);
        supply_above_3v0 <= 1'b0;
        wait_ms(5);
        supply_above_3v0 <= 1'b1;
      end
    join
    wait_ms(20);
    rd(`REG_STATUS);
    `CHK(d[2:0], ST_OFF);
    ignite(110);
    wait_state(ST_NORMAL, 150);
    `CHK(d[2:0], ST_NORMAL);
    `CHK(ready_cnt, 1);
    `CHK((ready_cyc - fall_cyc) inside {[200 * MS:200 * MS + 20]}, 1);
    `CHK({pwr.supplies_on, pwr.vdd_on, pwr.led_on, pwr.network_on}, 4'hf);
    seed = xs(seed);
    sample_mv <= 13'(seed[11:0]) + 13'h0bb8;
    wait_ms(1100);
    rd(`REG_VOLT);
    `CHK(d[12:0], sample_mv);
    seed = xs(seed);
    alarm_val = seed;
    wr(`REG_ALARM, alarm_val);
    wr(`REG_CMD, 32'(`CMD_POWER_DOWN));
    wait_state(ST_OFF, 5);
    `CHK(pwr, 6'h00);
    rd(`REG_ALARM);
    `CHK(d, alarm_val);
    rtc_alarm <= 1'b1;
    wait_state(ST_ALARM, 5);
    `CHK(d[2:0], ST_ALARM);
    `CHK(alarm_cnt, 1);
    `CHK({pwr.led_on, pwr.network_on}, 2'h0);
    seed = xs(seed);
    capacity <= seed[7:0] | 8'h01;
    charger_detect <= 1'b1;
    wait_ms(2);
    `CHK(pwr.charge_on, 0);
    rd(`REG_CHARGE);
    `CHK(d[8:0], 9'h100);
    for (int c = 1; c <= 5; c++) begin
      seed = xs(seed);
      wr(`REG_CMD, (c < 5) ? 32'(c) : 32'(6 + seed % 250));
      rd(`REG_STATUS);
      `CHK(d[5:0], {c < 5, 2'b10, ST_ALARM});
    end
    rtc_alarm <= 1'b0;
    ignite(110);
    wait_state(ST_NORMAL, 150);
    `CHK(d[2:0], ST_NORMAL);
    charger_detect <= 1'b0;
    overtemperature <= 1'b1;
    wait_state(ST_OFF, 5);
    `CHK(d[2:0], ST_OFF);
    overtemperature <= 1'b0;
    undervoltage <= 1'b1;
    ignite(110);
    wait_ms(120);
    rd(`REG_STATUS);
    `CHK(ready_cnt, 2);
    `CHK(d[2:0], ST_OFF);
    undervoltage <= 1'b0;
    charger_detect <= 1'b1;
    wait_state(ST_CHARGE_ONLY, 5);
    `CHK({pwr.charge_on, pwr.network_on, pwr.serial_full}, 3'h4);
    ignite(500);
    rd(`REG_STATUS);
    `CHK(d[2:0], ST_CHARGE_ONLY);
    ignite(1010);
    wait_state(ST_NORMAL, 150);
    `CHK(d[2:0], ST_NORMAL);
    charger_detect <= 1'b0;
    @(posedge clock);
    eoff_go <= 1'b1;
    @(posedge clock);
    eoff_go <= 1'b0;
    repeat (10) @(negedge clock);
    `CHK(pwr.supplies_on, 0);
    wait_idle;
    rd(`REG_STATUS);
    `CHK(d[2:0], ST_OFF);
    // autobaud on: start-up must stay silent
    wr(`REG_CTRL, 32'h1);
    ignite(110);
    wait_state(ST_NORMAL, 150);
    `CHK(ready_cnt, 3);
    summarize;
  end
endmodule : module_power_mode_sequencer_tb_top
